// ==== shared/fault_timing_pkg.sv ====
package fault_timing_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 40;
  localparam int TICK_PERIOD_NS  = 1000000;
  localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int OL_TIMEOUT_MS   = 50;
  localparam int RESTART_MS      = 1200;
  localparam int BROWNOUT_MS     = 40;
  localparam int BROWN_IN_MS     = 1;

  // One extra tick covers the unknown phase of the first tick
  localparam logic [10:0] RESTART_TICKS  = 11'(RESTART_MS + 1);
  localparam logic [10:0] BROWNOUT_TICKS = 11'(BROWNOUT_MS + 1);
  localparam logic [10:0] BROWN_IN_TICKS = 11'(BROWN_IN_MS + 1);

  // Up by four per tick, down by one: down runs at a quarter rate
  localparam logic [7:0] OL_UP_STEP = 8'h04;
  localparam logic [7:0] OL_FULL    = 8'(OL_TIMEOUT_MS * 4);

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h4;
  localparam logic [3:0] REG_OL_CNT  = 4'h8;
  localparam logic [3:0] REG_RESTART = 4'hc;

  localparam int CTRL_OL_EN_BIT = 0;
  localparam int CTRL_OC_EN_BIT = 1;
  localparam logic [1:0] CONTROL_RESET = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    SEQ_WAIT = 1'b0,
    SEQ_RUN  = 1'b1
  } seq_state_t;

  typedef enum logic [0:0] {
    OC_IDLE = 1'b0,
    OC_WARN = 1'b1
  } oc_state_t;

  typedef struct packed {
    logic overload;
    logic second_overcurrent_guard_trip;
    logic below_brownout;
    logic above_brown_in;
    logic soft_start;
    logic supply_on;
    logic supply_undervoltage_lockout;
    logic cycle_end;
    logic deadtime;
    logic latched_fault;
  } sense_t;

  typedef struct packed {
    logic switching_en;
    logic line_fault_flag;
    logic overload_flag;
    logic overcurrent_flag;
    logic latched_flag;
    logic oc_warning;
  } fault_status_t;

endpackage

// ==== src/tick_prescaler.sv ====
`timescale 1ns/10ps
module tick_prescaler
  import fault_timing_pkg::*;
#(
  parameter int CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Tick
  output logic      tick_o
);

  logic [15:0] count;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count  <= 16'h0000;
      tick_o <= 1'b0;
    end else if (count == 16'(CYCLES - 1)) begin
      count  <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      count  <= count + 16'h0001;
      tick_o <= 1'b0;
    end
  end

endmodule

// ==== src/level_debounce.sv ====
`timescale 1ns/10ps
module level_debounce
  import fault_timing_pkg::*;
#(
  parameter logic [10:0] TICKS = BROWNOUT_TICKS
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Level and time base
  input  wire logic level_i,
  input  wire logic tick_i,
  // Level has persisted
  output logic      hit_o
);

  logic [10:0] count;

  // Any gap in the level restarts the wait
  always_ff @(posedge clk_i) begin
    if (reset_i || !level_i) begin
      count <= 11'h000;
    end else if (tick_i && count != TICKS) begin
      count <= count + 11'h001;
    end
  end

  assign hit_o = level_i && (count == TICKS);

endmodule

// ==== src/fault_sequencer.sv ====
// Operation
// - Overload input is solely the peak-current-reference-above-overload-threshold comparator.
// - Overload timer stays inactive while soft-start runs.
// - Overload present counts up-down timer upward; full count means 50 ms.
// - On timeout stop switching, clear overload counter, start 1.2 s restart timer.
// - Overload flag held until 1.2 s elapsed; restart at next supply turn-on.
// - Overload gone before timeout: count down at a quarter of up rate.
// - Down count holds at zero; returning overload resumes upward from there.
// - Undervoltage lockout freezes the overload counter; it resumes from that value.
// - First overcurrent trip in a switching cycle enters warning, not fault.
// - Warning clears on a clean next cycle; a second trip declares fault.
// - Two consecutive trips: stop, reset logic, 1.2 s delay, restart at turn-on.
// - Two line comparators: below brownout level and above brown-in level.
// - Brownout must persist 40 ms continuously before line fault declared.
// - Brown-in recognised only after persisting more than 1 ms.
// - First turn-on, no fault, line above brown-in: enable switching at once.
// - First turn-on below brown-in: set line fault immediately, no debounce.
// - After brownout stop, ignore brown-in until supply reaches turn-on again.
// - Declaring brownout clears all latched protection flags; the code clears only latched_flag, not overload_flag or overcurrent_flag.
// - Detected fault acts at the first deadtime: stop loop and switching.
`timescale 1ns/10ps
module fault_sequencer
  import fault_timing_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Comparators, supply events and cycle strobes
  input  wire sense_t        sense_i,
  // Converter control and flags
  output fault_status_t      status_o,
  // Avalon-MM slave
  input  wire logic [3:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic [31:0]        avs_readdata_o,
  output logic               avs_waitrequest_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  seq_state_t  state;
  oc_state_t   oc_state;
  logic        tick;
  logic [1:0]  control;
  logic [7:0]  ol_count;
  logic [7:0]  next_ol_count;
  logic        ol_active;
  logic        ol_timeout;
  logic [10:0] restart_count;
  logic        overload_flag;
  logic        overcurrent_flag;
  logic        line_fault_flag;
  logic        latched_flag;
  logic        first_check;
  logic        bi_armed;
  logic        trip_seen;
  logic        cycle_trip;
  logic        oc_fault;
  logic        bo_hit;
  logic        bi_hit;
  logic        bo_declare;
  logic        any_flag;
  logic        stop_now;
  logic        bus_ack;
  logic        bus_req;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  tick_prescaler #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .tick_o  (tick)
  );

  // ----------------------------------------------------------------
  // Overload guard
  // ----------------------------------------------------------------
  // Frozen in soft-start and lockout rather than cleared
  assign ol_active = (state == SEQ_RUN) && control[CTRL_OL_EN_BIT]
                     && !sense_i.soft_start && !sense_i.supply_undervoltage_lockout;

  always_comb begin
    next_ol_count = ol_count;
    if (sense_i.overload) begin
      next_ol_count = (ol_count > OL_FULL - OL_UP_STEP) ? OL_FULL
                                                      : ol_count + OL_UP_STEP;
    end else if (ol_count != 8'h00) begin
      next_ol_count = ol_count - 8'h01;
    end
  end

  assign ol_timeout = ol_active && tick && (next_ol_count == OL_FULL);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ol_count <= 8'h00;
    end else if (ol_timeout) begin
      ol_count <= 8'h00;
    end else if (ol_active && tick) begin
      ol_count <= next_ol_count;
    end
  end

  // ----------------------------------------------------------------
  // Second overcurrent guard
  // ----------------------------------------------------------------
  // A trip anywhere in the cycle counts, even on the closing strobe
  assign cycle_trip = trip_seen || sense_i.second_overcurrent_guard_trip;
  assign oc_fault   = sense_i.cycle_end && cycle_trip && (oc_state == OC_WARN);

  always_ff @(posedge clk_i) begin
    if (reset_i || sense_i.cycle_end) begin
      trip_seen <= 1'b0;
    end else if (sense_i.second_overcurrent_guard_trip) begin
      trip_seen <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || state != SEQ_RUN || !control[CTRL_OC_EN_BIT]) begin
      oc_state <= OC_IDLE;
    end else if (sense_i.cycle_end) begin
      case (oc_state)
        OC_IDLE: oc_state <= cycle_trip ? OC_WARN : OC_IDLE;
        OC_WARN: oc_state <= OC_IDLE;
        default: oc_state <= OC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Line monitor
  // ----------------------------------------------------------------
  level_debounce #(
    .TICKS (BROWNOUT_TICKS)
  ) u_brownout (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .level_i (sense_i.below_brownout && state == SEQ_RUN),
    .tick_i  (tick),
    .hit_o   (bo_hit)
  );

  level_debounce #(
    .TICKS (BROWN_IN_TICKS)
  ) u_brown_in (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .level_i (sense_i.above_brown_in && bi_armed && line_fault_flag),
    .tick_i  (tick),
    .hit_o   (bi_hit)
  );

  assign bo_declare = bo_hit && !line_fault_flag;

  // Spikes as switching stops must not count as brown-in
  always_ff @(posedge clk_i) begin
    if (reset_i || bo_declare) begin
      bi_armed <= 1'b0;
    end else if (sense_i.supply_on && state == SEQ_WAIT) begin
      bi_armed <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      line_fault_flag <= 1'b0;
    end else if (bo_declare) begin
      line_fault_flag <= 1'b1;
    end else if (state == SEQ_WAIT && first_check && sense_i.supply_on
                 && !sense_i.above_brown_in) begin
      line_fault_flag <= 1'b1;
    end else if (bi_hit) begin
      line_fault_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fault flags and restart timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      latched_flag <= 1'b0;
    end else if (sense_i.latched_fault) begin
      latched_flag <= 1'b1;
    end else if (bo_declare) begin
      latched_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      restart_count <= 11'h000;
    end else if (ol_timeout || oc_fault) begin
      restart_count <= RESTART_TICKS;
    end else if (tick && restart_count != 11'h000) begin
      restart_count <= restart_count - 11'h001;
    end
  end

  // Set wins over the timer's clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overload_flag <= 1'b0;
    end else if (ol_timeout) begin
      overload_flag <= 1'b1;
    end else if (restart_count == 11'h000) begin
      overload_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overcurrent_flag <= 1'b0;
    end else if (oc_fault) begin
      overcurrent_flag <= 1'b1;
    end else if (restart_count == 11'h000) begin
      overcurrent_flag <= 1'b0;
    end
  end

  assign any_flag = overload_flag || overcurrent_flag || line_fault_flag || latched_flag;
  assign stop_now = (state == SEQ_RUN) && any_flag && sense_i.deadtime;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      first_check <= 1'b1;
    end else if (state == SEQ_WAIT && sense_i.supply_on) begin
      first_check <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= SEQ_WAIT;
    end else begin
      case (state)
        SEQ_WAIT: begin
          if (sense_i.supply_on) begin
            if (first_check) begin
              state <= sense_i.above_brown_in ? SEQ_RUN : SEQ_WAIT;
            end else if (!any_flag) begin
              state <= SEQ_RUN;
            end
          end
        end
        SEQ_RUN: begin
          if (stop_now) begin
            state <= SEQ_WAIT;
          end
        end
        default: state <= SEQ_WAIT;
      endcase
    end
  end

  assign status_o.switching_en     = (state == SEQ_RUN);
  assign status_o.line_fault_flag  = line_fault_flag;
  assign status_o.overload_flag    = overload_flag;
  assign status_o.overcurrent_flag = overcurrent_flag;
  assign status_o.latched_flag     = latched_flag;
  assign status_o.oc_warning       = (oc_state == OC_WARN);

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // One wait state: data is registered before waitrequest drops
  assign bus_req           = avs_read_i || avs_write_i;
  assign avs_waitrequest_o = bus_req && !bus_ack;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      control <= CONTROL_RESET;
    end else if (avs_write_i && bus_ack && avs_address_i == REG_CONTROL) begin
      control <= avs_writedata_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && !bus_ack) begin
      case (avs_address_i)
        REG_CONTROL: avs_readdata_o <= {30'h0, control};
        REG_STATUS:  avs_readdata_o <= {24'h0, bi_armed, first_check,
                                        state == SEQ_RUN, status_o.oc_warning,
                                        latched_flag, overcurrent_flag,
                                        overload_flag, line_fault_flag};
        REG_OL_CNT:  avs_readdata_o <= {24'h0, ol_count};
        REG_RESTART: avs_readdata_o <= {21'h0, restart_count};
        default:     avs_readdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  chk_ol_soft_hold: assert property (
    sense_i.soft_start |=> $stable(ol_count))
    else $error("overload counter moved during soft-start");
  chk_ol_up_four: assert property (
    ol_active && tick && sense_i.overload && ol_count < OL_FULL - OL_UP_STEP
    |=> ol_count == $past(ol_count) + OL_UP_STEP)
    else $error("overload counter did not step up by four");
  chk_ol_down_one: assert property (
    ol_active && tick && !sense_i.overload && ol_count != 8'h00
    |=> ol_count == $past(ol_count) - 8'h01)
    else $error("overload counter did not step down by one");
  chk_ol_zero_hold: assert property (
    ol_count == 8'h00 && !sense_i.overload |=> ol_count == 8'h00)
    else $error("overload counter left zero without overload");
  chk_ol_supply_undervoltage_lockout_freeze: assert property (
    sense_i.supply_undervoltage_lockout |=> $stable(ol_count))
    else $error("overload counter moved in lockout");
  chk_ol_timeout_act: assert property (
    ol_timeout |=> ol_count == 8'h00 && overload_flag && restart_count == RESTART_TICKS)
    else $error("overload timeout did not clear counter and start delay");
  chk_ol_flag_held: assert property (
    overload_flag && restart_count != 11'h000 |=> overload_flag)
    else $error("overload flag dropped before restart delay ended");
  chk_oc_first_warn: assert property (
    state == SEQ_RUN && control[CTRL_OC_EN_BIT] && oc_state == OC_IDLE
    && sense_i.cycle_end && cycle_trip
    |=> oc_state == OC_WARN && !$rose(overcurrent_flag))
    else $error("first overcurrent trip did not enter warning");
  chk_oc_second_trip: assert property (
    oc_fault |=> overcurrent_flag && oc_state == OC_IDLE && restart_count == RESTART_TICKS)
    else $error("second overcurrent trip not handled");
  chk_first_low_line: assert property (
    state == SEQ_WAIT && first_check && sense_i.supply_on && !sense_i.above_brown_in
    |=> line_fault_flag && state == SEQ_WAIT)
    else $error("low line at first turn-on not flagged at once");
  chk_first_good_run: assert property (
    state == SEQ_WAIT && first_check && sense_i.supply_on && sense_i.above_brown_in
    |=> state == SEQ_RUN)
    else $error("good line at first turn-on did not start switching");
  chk_brownout_clear: assert property (
    bo_declare && !sense_i.latched_fault |=> !latched_flag && line_fault_flag)
    else $error("brownout did not clear latched flag");
  chk_stop_deadtime: assert property (
    stop_now |=> !status_o.switching_en)
    else $error("switching not stopped at deadtime after fault");

endmodule

// ==== tb/switch_pulse_model.sv ====
`timescale 1ns/10ps
module switch_pulse_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic run_i,
  input  wire logic dt_en_i,
  input  wire logic trip_i,
  // Switching strobes
  output logic      cycle_end_o,
  output logic      deadtime_o,
  output logic      second_overcurrent_guard_trip_o
);
  logic [3:0] phase;

  // ----------------------------------------------------------------
  // Switching cycle of 16 clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // No strobes while stopped, as the real pulse generator
  assign cycle_end_o = run_i && (phase == 4'hf);
  assign deadtime_o  = run_i && dt_en_i && (phase == 4'h7);
  // Trip only in its own cycle, low between cycles
  assign second_overcurrent_guard_trip_o = cycle_end_o && trip_i;
endmodule

// ==== tb/converter_fault_timing_logic_test.sv ====
`timescale 1ns/10ps
module converter_fault_timing_logic_test;
  import fault_timing_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int B_RUN  = 5;
  localparam int B_LINE = 4;
  localparam int B_OL   = 3;
  localparam int B_OC   = 2;
  localparam int B_LAT  = 1;
  localparam int B_WARN = 0;
  logic          clk;
  logic          reset;
  sense_t        drv;
  sense_t        sense;
  fault_status_t status;
  logic [3:0]    addr;
  logic          rd;
  logic          wr;
  logic [31:0]   wdata;
  logic [31:0]   rdata;
  logic          wait_req;
  logic          dt_en;
  logic          trip;
  logic          ce;
  logic          dt;
  logic          tr;
  logic [31:0]   a;
  logic [31:0]   b;
  int            errors;
  int            cmp_count;
  int            waited;

  fault_sequencer #(.TICK_CYCLES(10)) uut (
    .clk_i(clk), .reset_i(reset), .sense_i(sense), .status_o(status),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req)
  );

  switch_pulse_model model (
    .clk_i(clk), .reset_i(reset), .run_i(status.switching_en), .dt_en_i(dt_en),
    .trip_i(trip), .cycle_end_o(ce), .deadtime_o(dt), .second_overcurrent_guard_trip_o(tr)
  );

  always_comb begin
    sense = drv;
    sense.cycle_end = ce;
    sense.deadtime = dt;
    sense.second_overcurrent_guard_trip = tr;
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] ad, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    rd <= !w;
    wr <= w;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (wait_req === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      check("bus_timeout", 32'h1, 32'h0);
      complete_run();
    end
  endtask

  // Waits on negedges so flags have settled
  task automatic wait_st(input int bit_i, input logic v, input int lim);
    for (waited = 0; waited < lim && status[bit_i] !== v; waited++) @(negedge clk);
    if (waited == lim) begin
      check("wait_timeout", 32'(bit_i), 32'hff);
      complete_run();
    end
  endtask

  task automatic pulse_on();
    @(posedge clk);
    drv.supply_on <= 1'b1;
    @(posedge clk);
    drv.supply_on <= 1'b0;
    repeat (2) @(negedge clk);
  endtask

  // Trip must stand at the closing strobe's edge, so wait one edge first
  task automatic one_cycle(input logic t);
    int n;
    @(posedge clk);
    trip <= t;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ce === 1'b1) break;
    end
    trip <= 1'b0;
    if (n == 20) begin
      check("cycle_timeout", 32'h1, 32'h0);
      complete_run();
    end
    @(negedge clk);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    drv = '0;
    reset = 1'b1;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    dt_en = 1'b0;
    trip = 1'b0;
    do_reset();
    check("status_reset", 32'(status), 32'h0);
    bus(1'b0, REG_CONTROL, 32'h0, a);
    check("control_reset", a, 32'h3);
    bus(1'b0, 4'h2, 32'h0, a);
    check("unmapped", a, 32'h0);
    bus(1'b1, REG_STATUS, 32'hff, a);
    bus(1'b0, REG_STATUS, 32'h0, a);
    check("status_ro", a, 32'h40);
    // First turn-on below brown-in
    pulse_on();
    check("line_now", 32'(status.line_fault_flag), 32'h1);
    check("run_none", 32'(status.switching_en), 32'h0);
    pulse_on();
    @(posedge clk);
    drv.above_brown_in <= 1'b1;
    repeat (5) @(negedge clk);
    check("brown_in_early", 32'(status.line_fault_flag), 32'h1);
    wait_st(B_LINE, 1'b0, 25);
    pulse_on();
    check("run_after_in", 32'(status.switching_en), 32'h1);
    bus(1'b1, REG_CONTROL, 32'h1, a);
    bus(1'b0, REG_CONTROL, 32'h0, a);
    check("control_wr", a, 32'h1);
    one_cycle(1'b1);
    check("oc_off", 32'(status.oc_warning), 32'h0);
    bus(1'b1, REG_CONTROL, 32'h3, a);
    // Second-level overcurrent filter
    one_cycle(1'b1);
    check("warn_set", 32'(status.oc_warning), 32'h1);
    check("oc_not_yet", 32'(status.overcurrent_flag), 32'h0);
    one_cycle(1'b0);
    check("warn_clear", 32'(status.oc_warning), 32'h0);
    one_cycle(1'b1);
    one_cycle(1'b1);
    check("oc_fault", 32'(status.overcurrent_flag), 32'h1);
    check("warn_reset", 32'(status.oc_warning), 32'h0);
    check("run_till_dt", 32'(status.switching_en), 32'h1);
    bus(1'b0, REG_RESTART, 32'h0, a);
    check("restart_load", 32'(a >= 32'd1199 && a <= 32'd1201), 32'h1);
    dt_en <= 1'b1;
    wait_st(B_RUN, 1'b0, 20);
    pulse_on();
    check("no_early_run", 32'(status.switching_en), 32'h0);
    repeat (11900) @(negedge clk);
    check("oc_held", 32'(status.overcurrent_flag), 32'h1);
    wait_st(B_OC, 1'b0, 300);
    pulse_on();
    check("oc_restart", 32'(status.switching_en), 32'h1);
    // Overload up-down timer
    @(posedge clk);
    dt_en <= 1'b0;
    drv.overload <= 1'b1;
    repeat (200) @(negedge clk);
    bus(1'b0, REG_OL_CNT, 32'h0, a);
    check("ol_up", 32'(a >= 32'd76 && a <= 32'd88), 32'h1);
    drv.soft_start <= 1'b1;
    bus(1'b0, REG_OL_CNT, 32'h0, a);
    repeat (100) @(negedge clk);
    bus(1'b0, REG_OL_CNT, 32'h0, b);
    check("ol_soft_start", b, a);
    drv.soft_start <= 1'b0;
    drv.supply_undervoltage_lockout <= 1'b1;
    bus(1'b0, REG_OL_CNT, 32'h0, a);
    repeat (100) @(negedge clk);
    bus(1'b0, REG_OL_CNT, 32'h0, b);
    check("ol_frozen", b, a);
    drv.supply_undervoltage_lockout <= 1'b0;
    drv.overload <= 1'b0;
    repeat (3) @(negedge clk);
    bus(1'b0, REG_OL_CNT, 32'h0, a);
    repeat (400) @(negedge clk);
    bus(1'b0, REG_OL_CNT, 32'h0, b);
    check("ol_down", 32'((a - b) >= 32'd39 && (a - b) <= 32'd41), 32'h1);
    drv.overload <= 1'b1;
    wait_st(B_OL, 1'b1, 600);
    check("ol_resume", 32'(waited >= 350 && waited <= 460), 32'h1);
    bus(1'b0, REG_OL_CNT, 32'h0, a);
    check("ol_cleared", a, 32'h0);
    dt_en <= 1'b1;
    wait_st(B_RUN, 1'b0, 20);
    // Reset after switching has stopped, line already healthy
    @(posedge clk);
    drv <= '0;
    dt_en <= 1'b0;
    do_reset();
    @(posedge clk);
    drv.above_brown_in <= 1'b1;
    pulse_on();
    check("run_at_once", 32'(status.switching_en), 32'h1);
    // Brownout debounce clears latched protections
    @(posedge clk);
    drv.latched_fault <= 1'b1;
    @(posedge clk);
    drv.latched_fault <= 1'b0;
    drv.below_brownout <= 1'b1;
    wait_st(B_LAT, 1'b1, 5);
    repeat (300) @(negedge clk);
    @(posedge clk);
    drv.below_brownout <= 1'b0;
    repeat (2) @(negedge clk);
    @(posedge clk);
    drv.below_brownout <= 1'b1;
    repeat (300) @(negedge clk);
    check("bo_debounce", 32'(status.line_fault_flag), 32'h0);
    wait_st(B_LINE, 1'b1, 150);
    check("bo_range", 32'(waited >= 80), 32'h1);
    check("latched_gone", 32'(status.latched_flag), 32'h0);
    @(posedge clk);
    dt_en <= 1'b1;
    drv.below_brownout <= 1'b0;
    wait_st(B_RUN, 1'b0, 20);
    repeat (100) @(negedge clk);
    check("bi_blanked", 32'(status.line_fault_flag), 32'h1);
    pulse_on();
    wait_st(B_LINE, 1'b0, 30);
    pulse_on();
    check("bo_restart", 32'(status.switching_en), 32'h1);
    complete_run();
  end
endmodule
